// ### logic/fss_pkg.sv
// Purpose: Shared constants for the flag-skip and serial display-send unit
// Assumes: 8-bit opcodes, 12-bit program counter, 24-bit accumulators
// Notes: Opcode map and instruction lengths are the core's encoding
`default_nettype none
package fss_pkg;
   localparam int PC_W = 12;
   localparam int ACC_W = 24;
   localparam int BITS_W = 5;
   // Skip opcodes: upper six bits pick the test, low two bits hold the count
   localparam logic [5:0] OPC_SKIP_NEG = 6'h10;
   localparam logic [5:0] OPC_SKIP_POS = 6'h11;
   localparam logic [5:0] OPC_SKIP_NOVF = 6'h12;
   localparam logic [5:0] OPC_SKIP_OVF = 6'h13;
   localparam logic [7:0] OPC_SEND = 8'hE8;
   // Length classes taken from the top three opcode bits
   localparam logic [2:0] CLS_LEN7 = 3'h7;
   localparam logic [2:0] CLS_LEN3 = 3'h6;
   localparam logic [2:0] CLS_LEN2 = 3'h5;
   localparam logic [PC_W-1:0] LEN_1 = 12'h001;
   localparam logic [PC_W-1:0] LEN_2 = 12'h002;
   localparam logic [PC_W-1:0] LEN_3 = 12'h003;
   localparam logic [PC_W-1:0] LEN_7 = 12'h007;
   localparam logic [PC_W-1:0] SKIP_OP_LEN = LEN_1;
   localparam logic [PC_W-1:0] SEND_OP_LEN = LEN_7;
   // Serial clock: half period in core cycles at 100 MHz
   localparam int CLK_HZ = 100_000_000;
   localparam int SCLK_HZ = 1_000_000;
   localparam int SCLK_HALF_CYC = (CLK_HZ / SCLK_HZ) / 2;
   localparam logic [ACC_W-1:0] ACC_ZERO = 24'h000000;
   localparam logic [BITS_W-1:0] BITS_MAX = 5'h18;

   typedef enum logic [1:0] {ST_IDLE, ST_SKIP, ST_SEND} fss_state_t;

   // Byte length of an instruction from its opcode
   function automatic logic [PC_W-1:0] fss_len(input logic [7:0] opc);
      case (opc[7:5])
         CLS_LEN7: fss_len = LEN_7;
         CLS_LEN3: fss_len = LEN_3;
         CLS_LEN2: fss_len = LEN_2;
         default: fss_len = LEN_1;
      endcase
   endfunction : fss_len
endpackage : fss_pkg
`default_nettype wire

// ### logic/fss_unit.sv
// Purpose: Executes the flag-test skips and the serial display-send instruction
// Assumes: Program memory answers mem_data_in for mem_addr_out in the same cycle
// Notes: The core holds off further execution while busy_out is high
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - The negative skip jumps over p1 instructions when the sign flag is one.
// - The non-negative skip jumps over p1 instructions when the sign flag is zero.
// - The no-overflow skip jumps over p1 instructions when the overflow flag is zero.
// - The overflow skip jumps over p1 instructions when the overflow flag is one.
// - A taken skip adds the byte lengths of the next p1 instructions, p1 being 1 to 3.
// - A flag skip is one byte, keeps all flags and takes one cycle plus one per skipped op.
// - The display send shifts accumulator y out of the serial port.
// - Its operand gives the bit count, and it is a seven-byte subroutine-style op.
module fss_unit
   import fss_pkg::*;
#(
   parameter int SCLK_HALF = SCLK_HALF_CYC
) (
   input wire logic clk_in, // Core clock
   input wire logic sys_rst_in, // Synchronous reset, high
   input wire logic exec_in, // Opcode valid this cycle
   input wire logic [7:0] opcode_in, // Opcode being executed
   input wire logic [PC_W-1:0] pc_in, // Address of that opcode
   input wire logic sign_flag_in, // Sign of previous result
   input wire logic ovf_flag_in, // Overflow of previous result
   input wire logic [ACC_W-1:0] accu_y_in, // Accumulator y
   input wire logic [BITS_W-1:0] send_bits_in, // Bit count operand
   input wire logic [7:0] mem_data_in, // Program byte at mem_addr_out
   output logic [PC_W-1:0] mem_addr_out, // Program byte address
   output logic mem_rd_out, // Program read strobe
   output logic pc_load_out, // Load pc_next_out, one cycle
   output logic [PC_W-1:0] pc_next_out, // New program counter
   output logic busy_out, // Unit is executing
   output logic sclk_out, // Serial clock
   output logic sdo_out // Serial data, MSB first
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   fss_state_t state_r, state_nxt;
   logic [PC_W-1:0] addr_r, addr_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic [ACC_W-1:0] sh_r, sh_nxt;
   logic [BITS_W-1:0] bits_r, bits_nxt;
   logic [15:0] div_r, div_nxt;
   logic sclk_r, sclk_nxt;
   logic sdo_r, sdo_nxt;
   logic rd_r, rd_nxt;
   logic load_r, load_nxt;
   logic [PC_W-1:0] pcn_r, pcn_nxt;
   logic busy_r, busy_nxt;
   logic skip_op, take, tick;
   logic [BITS_W-1:0] nbits;

   // Skip decode and condition
   always_comb begin
      skip_op = exec_in && (opcode_in[7:2] == OPC_SKIP_NEG || opcode_in[7:2] == OPC_SKIP_POS ||
                opcode_in[7:2] == OPC_SKIP_NOVF || opcode_in[7:2] == OPC_SKIP_OVF);
      case (opcode_in[7:2])
         OPC_SKIP_NEG: take = sign_flag_in;
         OPC_SKIP_POS: take = !sign_flag_in;
         OPC_SKIP_NOVF: take = !ovf_flag_in;
         OPC_SKIP_OVF: take = ovf_flag_in;
         default: take = 1'b0;
      endcase
      // count zero is not a legal skip
      take = take && (opcode_in[1:0] != 2'h0);
      nbits = (send_bits_in > BITS_MAX) ? BITS_MAX : send_bits_in;
      tick = (div_r == 16'(SCLK_HALF - 1));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      bits_nxt = bits_r;
      div_nxt = 16'h0000;
      sclk_nxt = sclk_r;
      sdo_nxt = sdo_r;
      rd_nxt = 1'b0;
      load_nxt = 1'b0;
      pcn_nxt = pcn_r;
      case (state_r)
         ST_IDLE: begin
            if (skip_op && take) begin
               state_nxt = ST_SKIP;
               addr_nxt = pc_in + SKIP_OP_LEN;
               cnt_nxt = opcode_in[1:0];
               rd_nxt = 1'b1;
            end else if (skip_op) begin
               load_nxt = 1'b1;
               pcn_nxt = pc_in + SKIP_OP_LEN;
            end else if (exec_in && opcode_in == OPC_SEND) begin
               state_nxt = ST_SEND;
               sh_nxt = accu_y_in << (ACC_W - int'(nbits));
               sdo_nxt = accu_y_in[nbits - 5'h01];
               bits_nxt = nbits;
               pcn_nxt = pc_in + SEND_OP_LEN;
               if (nbits == 5'h00) begin
                  state_nxt = ST_IDLE;
                  load_nxt = 1'b1;
                  sdo_nxt = 1'b0;
               end
            end
         end
         ST_SKIP: begin
            // step over one op by its length
            addr_nxt = addr_r + fss_len(mem_data_in);
            cnt_nxt = cnt_r - 2'h1;
            rd_nxt = (cnt_r != 2'h1);
            if (cnt_r == 2'h1) begin
               state_nxt = ST_IDLE;
               load_nxt = 1'b1;
               pcn_nxt = addr_r + fss_len(mem_data_in);
            end
         end
         ST_SEND: begin
            div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
            if (tick && !sclk_r) begin
               sclk_nxt = 1'b1;
            end else if (tick) begin
               sclk_nxt = 1'b0;
               sh_nxt = sh_r << 1;
               sdo_nxt = sh_r[ACC_W-2];
               bits_nxt = bits_r - 5'h01;
               // return like a subroutine, past seven bytes
               if (bits_r == 5'h01) begin
                  state_nxt = ST_IDLE;
                  load_nxt = 1'b1;
                  sdo_nxt = 1'b0;
               end
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      busy_nxt = (state_nxt != ST_IDLE);
   end

   // Registers
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r <= ST_IDLE;
         addr_r <= 12'h000;
         cnt_r <= 2'h0;
         sh_r <= ACC_ZERO;
         bits_r <= 5'h00;
         div_r <= 16'h0000;
         sclk_r <= 1'b0;
         sdo_r <= 1'b0;
         rd_r <= 1'b0;
         load_r <= 1'b0;
         pcn_r <= 12'h000;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         bits_r <= bits_nxt;
         div_r <= div_nxt;
         sclk_r <= sclk_nxt;
         sdo_r <= sdo_nxt;
         rd_r <= rd_nxt;
         load_r <= load_nxt;
         pcn_r <= pcn_nxt;
         busy_r <= busy_nxt;
      end
   end

   // Outputs straight from flops
   assign mem_addr_out = addr_r;
   assign mem_rd_out = rd_r;
   assign pc_load_out = load_r;
   assign pc_next_out = pcn_r;
   assign busy_out = busy_r;
   assign sclk_out = sclk_r;
   assign sdo_out = sdo_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // Bit count and return base captured as a send starts
   logic [BITS_W-1:0] sent_total_r;
   logic [PC_W-1:0] send_ret_r;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sent_total_r <= 5'h00;
         send_ret_r <= 12'h000;
      end else if (state_r == ST_IDLE && state_nxt == ST_SEND) begin
         sent_total_r <= (send_bits_in > BITS_MAX) ? BITS_MAX : send_bits_in;
         send_ret_r <= pc_in;
      end
   end

   logic [BITS_W:0] rises_r;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || state_r == ST_IDLE) begin
         rises_r <= 6'h00;
      end else if (sclk_nxt && !sclk_r) begin
         rises_r <= rises_r + 6'h01;
      end
   end

   sequence s_skip_one(logic [5:0] opc, logic cond);
      state_r == ST_IDLE && exec_in && opcode_in == {opc, 2'h1} && cond;
   endsequence
   sequence s_land1;
      ##1 state_r == ST_SKIP ##1 pc_load_out;
   endsequence

   chk_neg_skip_taken: assert property (s_skip_one(OPC_SKIP_NEG, sign_flag_in) |-> s_land1)
      else $error("negative skip not taken");
   chk_pos_skip_taken: assert property (s_skip_one(OPC_SKIP_POS, !sign_flag_in) |-> s_land1)
      else $error("non-negative skip not taken");
   chk_novf_skip_taken: assert property (s_skip_one(OPC_SKIP_NOVF, !ovf_flag_in) |-> s_land1)
      else $error("no-overflow skip not taken");
   chk_ovf_skip_none: assert property (s_skip_one(OPC_SKIP_OVF, !ovf_flag_in) |=>
      pc_load_out && pc_next_out == $past(pc_in) + SKIP_OP_LEN)
      else $error("overflow skip wrongly taken");
   chk_skip_three_len: assert property (state_r == ST_IDLE && skip_op && take && opcode_in[1:0] == 2'h3
      |-> ##4 pc_load_out ##0 busy_out == 1'b0)
      else $error("three-op skip took wrong cycles");
   chk_skip_step_len: assert property (state_r == ST_SKIP && cnt_r != 2'h1
      |=> addr_r == $past(addr_r) + fss_len($past(mem_data_in)))
      else $error("skip step length wrong");
   chk_skip_landing: assert property (state_r == ST_SKIP && cnt_r == 2'h1
      |=> pc_load_out && pc_next_out == $past(addr_r) + fss_len($past(mem_data_in)))
      else $error("skip landing address wrong");
   chk_send_bit_count: assert property (state_r == ST_SEND && state_nxt == ST_IDLE
      |-> rises_r == {1'b0, sent_total_r})
      else $error("send clock count wrong");
   chk_send_return_pc: assert property (state_r == ST_SEND ##1 state_r == ST_IDLE
      |-> pc_load_out && pc_next_out == send_ret_r + SEND_OP_LEN)
      else $error("send did not return");
   chk_sclk_idle_low: assert property (state_r != ST_SEND |-> !sclk_out)
      else $error("serial clock active outside send");

endmodule : fss_unit
`default_nettype wire

// ### testbench/fss_far_model.sv
// Purpose: Program memory and display receiver on the far side of the unit
// Assumes: Receiver samples serial data at each rising serial clock
// Notes: Memory shows a moving pattern whenever it is not read
`default_nettype none
module fss_far_model
   import fss_pkg::*;
(
   input wire logic clk_in, // Core clock
   input wire logic [PC_W-1:0] mem_addr_in, // Program byte address
   input wire logic mem_rd_in, // Program read strobe
   output logic [7:0] mem_data_out, // Program byte
   input wire logic sclk_in, // Serial clock
   input wire logic sdo_in, // Serial data
   input wire logic rx_clr_in, // Clear receiver
   output logic [ACC_W-1:0] rx_data_out, // Bits received
   output logic [5:0] rx_cnt_out // Count of bits received
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem_r [0:4095];
   logic [7:0] junk_r = 8'h5A;
   logic sclk_d_r = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // Empty program at start
   initial begin
      for (int i = 0; i < 4096; i++) mem_r[i] = 8'h00;
   end
   always_comb mem_data_out = mem_rd_in ? mem_r[mem_addr_in] : junk_r;
   // Pattern changes every cycle
   always_ff @(posedge clk_in) junk_r <= ~junk_r + 8'h01;
   always_ff @(posedge clk_in) begin
      sclk_d_r <= sclk_in;
      if (rx_clr_in) begin
         rx_data_out <= ACC_ZERO;
         rx_cnt_out <= 6'h00;
      end else if (sclk_in && !sclk_d_r) begin
         rx_data_out <= {rx_data_out[ACC_W-2:0], sdo_in};
         rx_cnt_out <= rx_cnt_out + 6'h01;
      end
   end
endmodule : fss_far_model
`default_nettype wire

// ### testbench/test_fss_unit.sv
// Purpose: Self-checking bench for the flag skips and the display send
// Assumes: Serial half period shortened to two core cycles
// Notes: Skipped program bytes come from the far-side model
`default_nettype none
module test_fss_unit;
   import fss_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 2;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, exec_in = 1'b0, sign_flag_in = 1'b0, ovf_flag_in = 1'b0;
   logic [7:0] opcode_in = 8'h00, mem_data;
   logic [PC_W-1:0] pc_in = 12'h100, mem_addr, pc_next;
   logic [ACC_W-1:0] accu_y_in = ACC_ZERO, rx_data;
   logic [BITS_W-1:0] send_bits_in = 5'h00;
   logic mem_rd, pc_load, busy, sclk, sdo, rx_clr = 1'b1;
   logic [5:0] rx_cnt;
   logic [7:0] prog [4] = '{8'hE8, 8'hC4, 8'hA1, 8'h00};
   int fail_count = 0, checked = 0;
   fss_unit #(.SCLK_HALF(HALF)) fss_unit_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .exec_in(exec_in),
      .opcode_in(opcode_in), .pc_in(pc_in), .sign_flag_in(sign_flag_in), .ovf_flag_in(ovf_flag_in),
      .accu_y_in(accu_y_in), .send_bits_in(send_bits_in), .mem_data_in(mem_data), .mem_addr_out(mem_addr),
      .mem_rd_out(mem_rd), .pc_load_out(pc_load), .pc_next_out(pc_next), .busy_out(busy), .sclk_out(sclk),
      .sdo_out(sdo));
   fss_far_model fss_far_model_inst (.clk_in(clk_in), .mem_addr_in(mem_addr), .mem_rd_in(mem_rd),
      .mem_data_out(mem_data), .sclk_in(sclk), .sdo_in(sdo), .rx_clr_in(rx_clr), .rx_data_out(rx_data),
      .rx_cnt_out(rx_cnt));
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare one value, report mismatch
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk_val
   // Issue one opcode, return cycles until the load pulse
   task automatic issue(input logic [7:0] opc, output logic [31:0] cyc);
      @(posedge clk_in);
      exec_in <= 1'b1;
      opcode_in <= opc;
      @(posedge clk_in);
      exec_in <= 1'b0;
      cyc = 1;
      #1;
      while (pc_load !== 1'b1 && cyc < 2000) begin
         @(posedge clk_in);
         #1;
         cyc++;
      end
   endtask : issue
   // Own length decode of skipped opcodes
   function automatic logic [PC_W-1:0] op_len(input logic [7:0] opc);
      return (opc[7:5] == 3'h7) ? 12'h007 : (opc[7:5] == 3'h6) ? 12'h003 : (opc[7:5] == 3'h5) ? 12'h002 : 12'h001;
   endfunction : op_len
   // One skip opcode with given flags and count
   task automatic skip_case(input int op, input logic sgn, input logic ovf, input int p1, input logic taken);
      logic [31:0] cyc;
      logic [PC_W-1:0] exp_pc;
      int n;
      n = taken ? p1 : 0;
      exp_pc = pc_in + SKIP_OP_LEN;
      for (int i = 0; i < n; i++) exp_pc += op_len(prog[i]);
      @(posedge clk_in);
      sign_flag_in <= sgn;
      ovf_flag_in <= ovf;
      issue({6'h10 + 6'(op), 2'(p1)}, cyc);
      chk_val(cyc, 32'(1 + n));
      chk_val(32'(pc_next), 32'(exp_pc));
      chk_val(32'(busy), 32'h0);
   endtask : skip_case
   // All four flag tests, both flag levels, counts one to three
   task automatic test_skips;
      logic [PC_W-1:0] a;
      a = pc_in + SKIP_OP_LEN;
      // Each skipped op starts where the one before ends
      for (int i = 0; i < 4; i++) begin
         fss_far_model_inst.mem_r[a] = prog[i];
         a += op_len(prog[i]);
      end
      for (int op = 0; op < 4; op++) begin
         for (int f = 0; f < 2; f++) begin
            skip_case(op, (op < 2) ? f[0] : ~f[0], (op < 2) ? ~f[0] : f[0], 1 + (op + f) % 3,
               (op == 1 || op == 2) ? ~f[0] : f[0]);
         end
      end
      skip_case(0, 1'b1, 1'b0, 0, 1'b0);
      skip_case(1, 1'b0, 1'b0, 3, 1'b1);
      $display("test_skips done");
   endtask : test_skips
   // One send: bits, timing and next address
   task automatic send_case(input logic [ACC_W-1:0] acc, input int bits);
      logic [31:0] cyc;
      int n;
      n = (bits > 24) ? 24 : bits;
      @(posedge clk_in);
      rx_clr <= 1'b0;
      accu_y_in <= acc;
      send_bits_in <= 5'(bits);
      issue(OPC_SEND, cyc);
      chk_val(cyc, 32'((n == 0) ? 1 : 1 + n * 2 * HALF));
      chk_val(32'(rx_cnt), 32'(n));
      chk_val(32'(rx_data), 32'(acc & ((32'h1 << n) - 1)));
      chk_val(32'(pc_next), 32'(pc_in + SEND_OP_LEN));
      chk_val(32'(sdo), 32'h0);
      rx_clr <= 1'b1;
   endtask : send_case
   // Sends of several lengths, firmware follow-up left to the program
   task automatic test_send;
      send_case(24'hA5C396, 5);
      send_case(24'hC3A55A, 24);
      send_case(24'h123456, 0);
      send_case(24'hF0F0F1, 30);
      $display("test_send done");
   endtask : test_send
   // Verdict and end of run
   task automatic test_done;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      #1;
      chk_val(32'({busy, pc_load, sdo, sclk, mem_rd, mem_addr, pc_next}), 32'h0);
      test_skips;
      test_send;
      test_done;
   end
   // Watchdog
   initial begin
      #200000;
      fail_count++;
      test_done;
   end
endmodule : test_fss_unit
`default_nettype wire
